// [logic/core_data_memory_map.sv]
// Data memory map of the core: banks, bit area, stack and special registers
`default_nettype none
module core_data_memory_map #(
	parameter int RAM_BYTES = 256 // Scratch-pad size, 256 or 128
) (
	input  wire logic                sys_clk_in,      // Core clock
	input  wire logic                arst_n_in,       // Async reset, active low
	input  wire dmem_pkg::mem_req_t  req_in,          // Decoder request
	input  wire logic [7:0]          port0_pins_in,   // Port zero pin levels
	input  wire logic                port_reset_high_cfg_cfg_in,     // Port reset high config
	output dmem_pkg::mem_rsp_t       rsp_out,         // Answer, next cycle
	output logic [7:0]               stack_ptr_out,   // Stack pointer
	output logic [1:0]               bank_out,        // Active bank number
	output logic [7:0]               arith_prim_out,  // Arithmetic primary register
	output logic [15:0]              code_addr_out,   // Code read address
	output logic [7:0]               port0_latch_out, // Port zero latch
	output logic [7:0]               keypad_out,      // Keypad input lines
	output logic                     timer1_in_out,   // Timer one input
	output dmem_pkg::nv_wr_t         nv_wr_out        // Nonvolatile write request
);
	// ***************************************************************
	// State of the block
	// ***************************************************************
	typedef struct packed {
		dmem_pkg::mem_rsp_t rsp;    // Registered answer
		logic [7:0]  sp;            // Stack pointer
		logic [7:0]  data_pointer_low;           // Data pointer low
		logic [7:0]  data_pointer_high;           // Data pointer high
		logic [7:0]  alu_status_word;           // ALU status word
		logic [7:0]  acc;           // Arithmetic primary register
		logic [7:0]  bop;           // Multiply/divide operand
		logic [7:0]  nv_addr;       // Nonvolatile write address
		logic [7:0]  nv_data;       // Nonvolatile write data
		logic [7:0]  nv_ctrl;       // Nonvolatile write control
		logic        nv_start;      // Start pulse
		logic [15:0] code_addr;     // Primary plus data pointer pair
	} core_state_t;

	core_state_t state_ff;  // Registered state
	core_state_t nxt_state; // Next state

	// ***************************************************************
	// Helper functions
	// ***************************************************************
	// Byte holding a bit address
	function automatic logic [7:0] bit_byte(input logic [7:0] a);
		bit_byte = a[7] ? {a[7:3], 3'b000}
		                : (dmem_pkg::BIT_AREA_BASE | {4'h0, a[6:3]});
	endfunction

	// Replace one bit of a byte
	function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] i,
	                                       input logic v);
		logic [7:0] r;
		r    = b;
		r[i] = v;
		set_bit = r;
	endfunction

	// ***************************************************************
	// Submodule wiring
	// ***************************************************************
	logic [7:0] ram_a_addr;  // Data read address
	logic [7:0] ram_a_data;  // Data read byte
	logic [7:0] ptr_addr;    // Address of active pointer register
	logic [7:0] ptr_data;    // Pointer value
	logic       wr_a_en;     // First RAM write
	logic [7:0] wr_a_addr;   // First RAM write address
	logic [7:0] wr_a_data;   // First RAM write byte
	logic       wr_b_en;     // Second RAM write
	logic [7:0] wr_b_addr;   // Second RAM write address
	logic [7:0] wr_b_data;   // Second RAM write byte
	logic       p0_wr_en;    // Port latch write
	logic [7:0] p0_latch;    // Port latch
	logic [7:0] p0_pins;     // Sampled pins
	logic [7:0] bank_base;   // First byte of active bank

	scratch_ram #(
		.DEPTH(RAM_BYTES)
	) u_ram (
		.sys_clk_in   (sys_clk_in),
		.arst_n_in    (arst_n_in),
		.rd_a_addr_in (ram_a_addr),
		.rd_a_data_out(ram_a_data),
		.rd_b_addr_in (ptr_addr),
		.rd_b_data_out(ptr_data),
		.wr_a_en_in   (wr_a_en),
		.wr_a_addr_in (wr_a_addr),
		.wr_a_data_in (wr_a_data),
		.wr_b_en_in   (wr_b_en),
		.wr_b_addr_in (wr_b_addr),
		.wr_b_data_in (wr_b_data)
	);

	port_zero_unit u_p0 (
		.sys_clk_in   (sys_clk_in),
		.arst_n_in    (arst_n_in),
		.port_reset_high_cfg_cfg_in  (port_reset_high_cfg_cfg_in),
		.pins_in      (port0_pins_in),
		.wr_en_in     (p0_wr_en),
		.wr_data_in   (wr_a_data),
		.latch_out    (p0_latch),
		.pins_out     (p0_pins),
		.keypad_out   (keypad_out),
		.timer1_in_out(timer1_in_out)
	);

	// Bank n starts at 8*n, selected by the two status bits
	assign bank_base = {3'b000, state_ff.alu_status_word[dmem_pkg::BANK_SEL_HI_POS],
	                    state_ff.alu_status_word[dmem_pkg::BANK_SEL_LOW_POS], 3'b000};
	// Pointer zero or one of the active bank gives the indirect address
	assign ptr_addr  = bank_base | {7'h00, req_in.ptr_sel};

	// ***************************************************************
	// Special register read mux
	// ***************************************************************
	// Only the direct and bit paths ever reach this
	function automatic logic [7:0] sfr_rd(input core_state_t s, input logic [7:0] a,
	                                     input logic rmw, input logic [7:0] latch,
	                                     input logic [7:0] pins);
		case (a)
			dmem_pkg::ADDR_PORT_ZERO:  sfr_rd = rmw ? latch : pins;
			dmem_pkg::ADDR_STACK_PTR:  sfr_rd = s.sp;
			dmem_pkg::ADDR_DATA_POINTER_PAIR_LOW:   sfr_rd = s.data_pointer_low;
			dmem_pkg::ADDR_DATA_POINTER_PAIR_HIGH:  sfr_rd = s.data_pointer_high;
			dmem_pkg::ADDR_NV_ADDRESS: sfr_rd = s.nv_addr;
			dmem_pkg::ADDR_NV_DATA:    sfr_rd = s.nv_data;
			dmem_pkg::ADDR_NV_CONTROL: sfr_rd = s.nv_ctrl;
			dmem_pkg::ADDR_ALU_STATUS: sfr_rd = s.alu_status_word;
			dmem_pkg::ADDR_ARITH_PRIM: sfr_rd = s.acc;
			dmem_pkg::ADDR_MUL_DIV:    sfr_rd = s.bop;
			default:                   sfr_rd = dmem_pkg::UNIMPL_READ;
		endcase
	endfunction

	// ***************************************************************
	// Access decode and next state
	// ***************************************************************
	always_comb begin
		logic [7:0] eff_addr;  // Byte actually addressed
		logic       to_sfr;    // Access lands in special space
		logic [7:0] rd_byte;   // Byte read for this access
		logic       do_wr;     // Byte is written back
		logic [7:0] wr_byte;   // Byte to write back
		logic [7:0] sp_inc;    // Stack pointer plus one
		logic [7:0] sp_inc2;   // Stack pointer plus two
		eff_addr  = req_in.addr;
		to_sfr    = 1'b0;
		do_wr     = 1'b0;
		wr_byte   = req_in.wdata;
		sp_inc    = state_ff.sp + 8'h01;
		sp_inc2   = state_ff.sp + 8'h02;
		rd_byte   = 8'h00;
		wr_b_en   = 1'b0;
		wr_b_addr = sp_inc2;
		wr_b_data = req_in.ret_addr[15:8];
		nxt_state = state_ff;
		nxt_state.rsp.valid = 1'b0;
		nxt_state.nv_start  = 1'b0;

		// Address selection by access kind, never by address value
		case (req_in.op)
			dmem_pkg::OP_DIR_RD, dmem_pkg::OP_DIR_WR: begin
				eff_addr = req_in.addr;
				to_sfr   = req_in.addr[7];
			end
			dmem_pkg::OP_IND_RD, dmem_pkg::OP_IND_WR: begin
				eff_addr = ptr_data;       // Upper half is RAM here
			end
			dmem_pkg::OP_BIT_RD, dmem_pkg::OP_BIT_WR: begin
				eff_addr = bit_byte(req_in.addr);
				to_sfr   = req_in.addr[7];
			end
			dmem_pkg::OP_REG_RD, dmem_pkg::OP_REG_WR: begin
				eff_addr = bank_base | {5'h00, req_in.addr[2:0]};
			end
			dmem_pkg::OP_PUSH, dmem_pkg::OP_CALL: begin
				eff_addr = sp_inc;         // Increment first
			end
			dmem_pkg::OP_POP: begin
				eff_addr = state_ff.sp;    // Read first
			end
			default: begin
				eff_addr = req_in.addr;
			end
		endcase
		ram_a_addr = eff_addr;

		// Read from the space that the access landed in
		rd_byte = to_sfr ? sfr_rd(state_ff, eff_addr,
		                          req_in.rmw || req_in.op == dmem_pkg::OP_BIT_WR,
		                          p0_latch, p0_pins)
		                 : ram_a_data;

		// Write-back selection
		case (req_in.op)
			dmem_pkg::OP_DIR_WR, dmem_pkg::OP_IND_WR, dmem_pkg::OP_REG_WR,
			dmem_pkg::OP_PUSH: begin
				do_wr = 1'b1;
			end
			dmem_pkg::OP_CALL: begin
				do_wr   = 1'b1;              // Return address, low then high
				wr_byte = req_in.ret_addr[7:0];
				wr_b_en = req_in.valid;
			end
			dmem_pkg::OP_BIT_WR: begin
				do_wr   = 1'b1;              // Modify one bit only
				wr_byte = set_bit(rd_byte, req_in.addr[2:0], req_in.wbit);
			end
			default: begin
				do_wr = 1'b0;
			end
		endcase
		do_wr = do_wr && req_in.valid;

		wr_a_en   = do_wr && !to_sfr;
		wr_a_addr = eff_addr;
		wr_a_data = wr_byte;
		p0_wr_en  = do_wr && to_sfr && eff_addr == dmem_pkg::ADDR_PORT_ZERO;

		// Special register writes; missing ones are ignored
		if (do_wr && to_sfr) begin
			case (eff_addr)
				dmem_pkg::ADDR_STACK_PTR:  nxt_state.sp      = wr_byte;
				dmem_pkg::ADDR_DATA_POINTER_PAIR_LOW:   nxt_state.data_pointer_low     = wr_byte;
				dmem_pkg::ADDR_DATA_POINTER_PAIR_HIGH:  nxt_state.data_pointer_high     = wr_byte;
				dmem_pkg::ADDR_NV_ADDRESS: nxt_state.nv_addr = wr_byte;
				dmem_pkg::ADDR_NV_DATA:    nxt_state.nv_data = wr_byte;
				dmem_pkg::ADDR_NV_CONTROL: begin
					nxt_state.nv_ctrl  = wr_byte;
					nxt_state.nv_start = wr_byte[dmem_pkg::NV_START_POS];
				end
				dmem_pkg::ADDR_ALU_STATUS: nxt_state.alu_status_word     = wr_byte;
				dmem_pkg::ADDR_ARITH_PRIM: nxt_state.acc     = wr_byte;
				dmem_pkg::ADDR_MUL_DIV:    nxt_state.bop     = wr_byte;
				default:                   nxt_state.alu_status_word     = state_ff.alu_status_word;
			endcase
		end

		// Stack pointer movement
		if (req_in.valid) begin
			case (req_in.op)
				dmem_pkg::OP_PUSH: nxt_state.sp = sp_inc;
				dmem_pkg::OP_CALL: nxt_state.sp = sp_inc2;
				dmem_pkg::OP_POP:  nxt_state.sp = state_ff.sp - 8'h01;
				default:           nxt_state.sp = nxt_state.sp;
			endcase
		end

		// Answer for every request, next cycle
		if (req_in.valid) begin
			nxt_state.rsp.valid = 1'b1;
			nxt_state.rsp.data  = rd_byte;
			nxt_state.rsp.bitv  = rd_byte[req_in.addr[2:0]]; // Missing bits read one
		end

		// Code read address for the separate program memory
		nxt_state.code_addr = {nxt_state.data_pointer_high, nxt_state.data_pointer_low}
		                      + {8'h00, nxt_state.acc};
	end

	// ***************************************************************
	// State register
	// ***************************************************************
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_ff    <= '0;
			state_ff.sp <= dmem_pkg::STACK_PTR_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ***************************************************************
	// Outputs, all from flip-flops
	// ***************************************************************
	assign rsp_out         = state_ff.rsp;
	assign stack_ptr_out   = state_ff.sp;
	assign bank_out        = bank_base[4:3];
	assign arith_prim_out  = state_ff.acc;
	assign code_addr_out   = state_ff.code_addr;
	assign port0_latch_out = p0_latch;
	assign nv_wr_out       = '{start: state_ff.nv_start, addr: state_ff.nv_addr,
	                           data: state_ff.nv_data, ctrl: state_ff.nv_ctrl[6:0]};
endmodule
`default_nettype wire

// [logic/dmem_pkg.sv]
// Shared constants and carrier types for the core data memory map
`default_nettype none
package dmem_pkg;
	// ***************************************************************
	// Direct-space addresses of the special registers
	// ***************************************************************
	localparam logic [7:0] ADDR_PORT_ZERO   = 8'h80; // Port zero latch / pins
	localparam logic [7:0] ADDR_STACK_PTR   = 8'h81; // Stack pointer
	localparam logic [7:0] ADDR_DATA_POINTER_PAIR_LOW    = 8'h82; // Data pointer low byte
	localparam logic [7:0] ADDR_DATA_POINTER_PAIR_HIGH   = 8'h83; // Data pointer high byte
	localparam logic [7:0] ADDR_NV_ADDRESS  = 8'hc6; // Nonvolatile write address
	localparam logic [7:0] ADDR_NV_CONTROL  = 8'hce; // Nonvolatile write control
	localparam logic [7:0] ADDR_NV_DATA     = 8'hcf; // Nonvolatile write data
	localparam logic [7:0] ADDR_ALU_STATUS  = 8'hd0; // ALU status word
	localparam logic [7:0] ADDR_ARITH_PRIM  = 8'he0; // Arithmetic primary register
	localparam logic [7:0] ADDR_MUL_DIV     = 8'hf0; // Multiply/divide operand

	// ***************************************************************
	// Region boundaries and field positions
	// ***************************************************************
	localparam logic [7:0] SFR_BASE         = 8'h80; // Special space starts here
	localparam logic [7:0] BIT_AREA_BASE    = 8'h20; // First bit-addressable byte
	localparam int         BANK_SEL_LOW_POS = 3;     // Bank select low in status word
	localparam int         BANK_SEL_HI_POS  = 4;     // Bank select high in status word
	localparam int         NV_START_POS     = 7;     // Write start bit in control reg
	localparam logic [7:0] UNIMPL_READ      = 8'hff; // Missing locations read high

	// ***************************************************************
	// Values after reset
	// ***************************************************************
	localparam logic [7:0] STACK_PTR_RESET  = 8'h07;
	localparam logic [7:0] REG_ZERO_RESET   = 8'h00;
	localparam logic [7:0] PORT_LATCH_HIGH  = 8'hff; // Port config bit set
	localparam logic [7:0] PORT_LATCH_LOW   = 8'h00; // Port config bit clear

	// ***************************************************************
	// Access kinds issued by the instruction decoder
	// ***************************************************************
	typedef enum logic [3:0] {
		OP_DIR_RD = 4'h0, // Direct byte read
		OP_DIR_WR = 4'h1, // Direct byte write
		OP_IND_RD = 4'h2, // Indirect read via working pointer
		OP_IND_WR = 4'h3, // Indirect write via working pointer
		OP_BIT_RD = 4'h4, // Single-bit read
		OP_BIT_WR = 4'h5, // Single-bit write
		OP_REG_RD = 4'h6, // Working register read, active bank
		OP_REG_WR = 4'h7, // Working register write, active bank
		OP_PUSH   = 4'h8, // Push one byte
		OP_POP    = 4'h9, // Pop one byte
		OP_CALL   = 4'ha  // Save return address, low byte first
	} op_kind_t;

	// Request from the decoder, one per cycle
	typedef struct packed {
		logic        valid;    // Request present this cycle
		op_kind_t    op;       // Access kind
		logic [7:0]  addr;     // Direct, bit or register address
		logic [7:0]  wdata;    // Byte to write or push
		logic        wbit;     // Bit value for bit writes
		logic        rmw;      // Read-modify-write: read latches
		logic        ptr_sel;  // Working pointer one when set
		logic [15:0] ret_addr; // Return address for calls
	} mem_req_t;

	// Answer, one cycle after the request
	typedef struct packed {
		logic       valid; // Answer present
		logic [7:0] data;  // Byte read
		logic       bitv;  // Bit read
	} mem_rsp_t;

	// Nonvolatile write request toward the data flash
	typedef struct packed {
		logic       start; // One-cycle start pulse
		logic [7:0] addr;  // Target byte
		logic [7:0] data;  // Byte to program
		logic [6:0] ctrl;  // Remaining control bits
	} nv_wr_t;
endpackage
`default_nettype wire

// [logic/scratch_ram.sv]
// Scratch-pad RAM in flip-flops with two read and two write ports
`default_nettype none
module scratch_ram #(
	parameter int DEPTH = 256 // Bytes of scratch-pad RAM
) (
	input  wire logic       sys_clk_in,   // Core clock
	input  wire logic       arst_n_in,    // Async reset, active low
	input  wire logic [7:0] rd_a_addr_in, // Data read address
	output logic      [7:0] rd_a_data_out,// Data read byte
	input  wire logic [7:0] rd_b_addr_in, // Pointer read address
	output logic      [7:0] rd_b_data_out,// Pointer read byte
	input  wire logic       wr_a_en_in,   // First write enable
	input  wire logic [7:0] wr_a_addr_in, // First write address
	input  wire logic [7:0] wr_a_data_in, // First write byte
	input  wire logic       wr_b_en_in,   // Second write enable
	input  wire logic [7:0] wr_b_addr_in, // Second write address
	input  wire logic [7:0] wr_b_data_in  // Second write byte
);
	// ***************************************************************
	// Storage
	// ***************************************************************
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem; // Byte array
	} ram_state_t;

	ram_state_t state_ff; // Registered storage
	ram_state_t nxt_state; // Next storage

	// Missing bytes on small parts read high
	function automatic logic [7:0] rd(input ram_state_t s, input logic [7:0] a);
		rd = (int'(a) < DEPTH) ? s.mem[a] : dmem_pkg::UNIMPL_READ;
	endfunction

	assign rd_a_data_out = rd(state_ff, rd_a_addr_in);
	assign rd_b_data_out = rd(state_ff, rd_b_addr_in);

	// Second port wins on the same byte; writes past the end drop
	always_comb begin
		nxt_state = state_ff;
		if (wr_a_en_in && int'(wr_a_addr_in) < DEPTH) begin
			nxt_state.mem[wr_a_addr_in] = wr_a_data_in;
		end
		if (wr_b_en_in && int'(wr_b_addr_in) < DEPTH) begin
			nxt_state.mem[wr_b_addr_in] = wr_b_data_in;
		end
	end

	// Clear on reset so simulation starts defined
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
endmodule
`default_nettype wire

// [logic/port_zero_unit.sv]
// Port zero latch, pin sampling and shared input functions
`default_nettype none
module port_zero_unit (
	input  wire logic       sys_clk_in,    // Core clock
	input  wire logic       arst_n_in,     // Async reset, active low
	input  wire logic       port_reset_high_cfg_cfg_in,   // Port reset high configuration
	input  wire logic [7:0] pins_in,       // Pin levels
	input  wire logic       wr_en_in,      // Latch write strobe
	input  wire logic [7:0] wr_data_in,    // Latch write byte
	output logic      [7:0] latch_out,     // Output latch
	output logic      [7:0] pins_out,      // Sampled pin levels
	output logic      [7:0] keypad_out,    // Keypad input lines
	output logic            timer1_in_out  // Timer one count input
);
	// ***************************************************************
	// State
	// ***************************************************************
	typedef struct packed {
		logic       primed; // Config has been applied since reset
		logic [7:0] latch;  // Output latch
		logic [7:0] pins;   // Pin sample
	} p0_state_t;

	p0_state_t state_ff;  // Registered state
	p0_state_t nxt_state; // Next state

	// Config is caught after release, never under the async reset
	always_comb begin
		nxt_state      = state_ff;
		nxt_state.pins = pins_in;
		if (!state_ff.primed) begin
			nxt_state.primed = 1'b1;
			nxt_state.latch  = port_reset_high_cfg_cfg_in ? dmem_pkg::PORT_LATCH_HIGH
			                               : dmem_pkg::PORT_LATCH_LOW;
		end else if (wr_en_in) begin
			nxt_state.latch = wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign latch_out     = state_ff.latch;
	assign pins_out      = state_ff.pins;
	assign keypad_out    = state_ff.pins;
	assign timer1_in_out = state_ff.pins[7];
endmodule
`default_nettype wire

// [sim/decoder_model.sv]
// Behavioural instruction decoder issuing one memory request at a time
`default_nettype none
module decoder_model (
	input  wire logic               sys_clk_in, // Core clock
	input  wire dmem_pkg::mem_rsp_t rsp_in,     // Answer from the map
	output var  dmem_pkg::mem_req_t req_out     // Request toward the map
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle until the first request
	initial req_out = '0;
	// Request held until its taking edge; answer read once that edge settled
	task automatic xfer(input dmem_pkg::op_kind_t k, input logic [7:0] a,
		input logic [7:0] w, input logic [2:0] f, output logic [7:0] d);
		@(posedge sys_clk_in);
		req_out <= '{1'b1, k, a, w, f[0], f[1], f[2], 16'h1234};
		@(posedge sys_clk_in);
		req_out.valid <= 1'b0;
		req_out.addr  <= ~a; // Released address never keeps the old value
		#1;
		d = rsp_in.data;
	endtask
endmodule
`default_nettype wire

// [sim/core_data_memory_map_monitor.sv]
// Concurrent port checks for the core data memory map
`default_nettype none
module core_data_memory_map_monitor (
	input wire logic               sys_clk_in,
	input wire logic               arst_n_in,
	input wire dmem_pkg::mem_req_t req_in,
	input wire logic [7:0]         port0_pins_in,
	input wire dmem_pkg::mem_rsp_t rsp_out,
	input wire logic [7:0]         stack_ptr_out,
	input wire logic [1:0]         bank_out,
	input wire logic [7:0]         keypad_out,
	input wire logic               timer1_in_out,
	input wire dmem_pkg::nv_wr_t   nv_wr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);
	// Request of one kind, and direct write to one address
	sequence s_op(dmem_pkg::op_kind_t k); req_in.valid && req_in.op == k; endsequence
	sequence s_wr(logic [7:0] a); s_op(dmem_pkg::OP_DIR_WR) ##0 req_in.addr == a; endsequence
	property p_answer; req_in.valid |=> rsp_out.valid; endproperty
	property p_push; s_op(dmem_pkg::OP_PUSH) |=> stack_ptr_out == $past(stack_ptr_out) + 8'h01;
	endproperty
	property p_pop; s_op(dmem_pkg::OP_POP) |=> stack_ptr_out == $past(stack_ptr_out) - 8'h01;
	endproperty
	property p_call; s_op(dmem_pkg::OP_CALL) |=> stack_ptr_out == $past(stack_ptr_out) + 8'h02;
	endproperty
	property p_spwr; s_wr(dmem_pkg::ADDR_STACK_PTR) |=> stack_ptr_out == $past(req_in.wdata);
	endproperty
	property p_bank; s_wr(dmem_pkg::ADDR_ALU_STATUS) |=> bank_out == $past(req_in.wdata[4:3]);
	endproperty
	property p_unimpl; s_op(dmem_pkg::OP_DIR_RD) ##0 req_in.addr == 8'h84 |=> rsp_out.data == 8'hff;
	endproperty
	property p_keypad; $past(arst_n_in) |-> keypad_out == $past(port0_pins_in)
		&& timer1_in_out == $past(port0_pins_in[7]); endproperty
	property p_nv; s_wr(dmem_pkg::ADDR_NV_CONTROL) ##0 req_in.wdata[7] |=> nv_wr_out.start;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	a_push: assert property (p_push) else $error("push pointer");
	a_pop: assert property (p_pop) else $error("pop pointer");
	a_call: assert property (p_call) else $error("call pointer");
	a_spwr: assert property (p_spwr) else $error("pointer write");
	a_bank: assert property (p_bank) else $error("bank select");
	a_unimpl: assert property (p_unimpl) else $error("empty read");
	a_keypad: assert property (p_keypad) else $error("keypad lines");
	a_nv: assert property (p_nv) else $error("nv start");
endmodule
bind core_data_memory_map core_data_memory_map_monitor u_mon (.sys_clk_in, .arst_n_in, .req_in,
	.port0_pins_in, .rsp_out, .stack_ptr_out, .bank_out, .keypad_out, .timer1_in_out, .nv_wr_out);
`default_nettype wire

// [sim/core_data_memory_map_tb.sv]
// Self-checking bench for the core data memory map
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module core_data_memory_map_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, arst_n, port_reset_high_cfg, tmr;
	logic [7:0] pins, stk, pri, lat, kpd, d;
	logic [1:0] bank;
	logic [15:0] cadr;
	dmem_pkg::mem_req_t req;
	dmem_pkg::mem_rsp_t rsp;
	dmem_pkg::nv_wr_t nv;
	int n_mismatch = 0;
	int n_compared = 0;
	core_data_memory_map #(.RAM_BYTES(256)) DUT (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
		.req_in(req), .port0_pins_in(pins), .port_reset_high_cfg_cfg_in(port_reset_high_cfg), .rsp_out(rsp),
		.stack_ptr_out(stk), .bank_out(bank), .arith_prim_out(pri), .code_addr_out(cadr),
		.port0_latch_out(lat), .keypad_out(kpd), .timer1_in_out(tmr), .nv_wr_out(nv));
	decoder_model m (.sys_clk_in(sys_clk), .rsp_in(rsp), .req_out(req));
	// Shorthands: f packs pointer select, read-modify-write and bit value
	task automatic op(dmem_pkg::op_kind_t k, logic [7:0] a, logic [7:0] w, logic [2:0] f);
		m.xfer(k, a, w, f, d);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] w);
		op(dmem_pkg::OP_DIR_WR, a, w, 3'h0);
	endtask
	task automatic rd(logic [7:0] a);
		op(dmem_pkg::OP_DIR_RD, a, 8'h00, 3'h0);
	endtask
	// Push, pop and call, pointer placed at 3f, above the bit area
	task automatic t_stack;
		`CHK("reset pointer", 8'h07, stk)
		`CHK("reset latch", 8'hff, lat)
		wr(dmem_pkg::ADDR_STACK_PTR, 8'h3f);
		op(dmem_pkg::OP_PUSH, 8'h00, 8'ha5, 3'h0);
		rd(8'h40);
		`CHK("pushed byte", 8'ha5, d)
		`CHK("answer valid", 1'b1, rsp.valid)
		op(dmem_pkg::OP_PUSH, 8'h00, 8'h5a, 3'h0);
		op(dmem_pkg::OP_POP, 8'h00, 8'h00, 3'h0);
		`CHK("popped byte", 8'h5a, d)
		`CHK("pointer after pop", 8'h40, stk)
		op(dmem_pkg::OP_CALL, 8'h00, 8'h00, 3'h0);
		op(dmem_pkg::OP_POP, 8'h00, 8'h00, 3'h0);
		`CHK("return high", 8'h12, d)
		op(dmem_pkg::OP_POP, 8'h00, 8'h00, 3'h0);
		`CHK("return low", 8'h34, d)
	endtask
	// Every bank gets its own register two; bank three stays active afterwards
	task automatic t_bank;
		for (int b = 0; b < 4; b++) begin
			wr(dmem_pkg::ADDR_ALU_STATUS, 8'(b << 3));
			`CHK("bank", 2'(b), bank)
			op(dmem_pkg::OP_REG_WR, 8'h02, 8'(8'h60 + b), 3'h0);
		end
		for (int b = 0; b < 4; b++) begin
			rd(8'(b * 8 + 2));
			`CHK("bank byte", 8'(8'h60 + b), d)
		end
		op(dmem_pkg::OP_REG_WR, 8'h01, 8'h84, 3'h0);
		op(dmem_pkg::OP_IND_WR, 8'h00, 8'h77, 3'h4);
		op(dmem_pkg::OP_IND_RD, 8'h00, 8'h00, 3'h4);
		`CHK("upper ram", 8'h77, d)
		rd(8'h84);
		`CHK("empty special", 8'hff, d)
	endtask
	// Bit area corners, a special-register bit, port and pointer paths
	task automatic t_misc;
		op(dmem_pkg::OP_BIT_WR, 8'h7f, 8'h00, 3'h1);
		op(dmem_pkg::OP_BIT_WR, 8'h00, 8'h00, 3'h1);
		rd(8'h2f);
		`CHK("bit 7f", 8'h80, d)
		rd(8'h20);
		`CHK("bit 00", 8'h01, d)
		op(dmem_pkg::OP_BIT_RD, 8'h7e, 8'h00, 3'h0);
		`CHK("area bit read", 1'b0, rsp.bitv)
		wr(dmem_pkg::ADDR_ARITH_PRIM, 8'h00);
		op(dmem_pkg::OP_BIT_WR, 8'he3, 8'h00, 3'h1);
		`CHK("special bit", 8'h08, pri)
		op(dmem_pkg::OP_BIT_RD, 8'he3, 8'h00, 3'h0);
		`CHK("special bit read", 1'b1, rsp.bitv)
		op(dmem_pkg::OP_BIT_RD, 8'h89, 8'h00, 3'h0);
		`CHK("missing bit", 1'b1, rsp.bitv)
		@(posedge sys_clk);
		pins <= 8'h9c;
		wr(dmem_pkg::ADDR_PORT_ZERO, 8'hc3);
		rd(dmem_pkg::ADDR_PORT_ZERO);
		`CHK("pin read", 8'h9c, d)
		op(dmem_pkg::OP_DIR_RD, dmem_pkg::ADDR_PORT_ZERO, 8'h00, 3'h2);
		`CHK("latch read", 8'hc3, d)
		`CHK("keypad", 8'h9c, kpd)
		`CHK("timer input", 1'b1, tmr)
		wr(dmem_pkg::ADDR_DATA_POINTER_PAIR_LOW, 8'h10);
		wr(dmem_pkg::ADDR_DATA_POINTER_PAIR_HIGH, 8'h20);
		wr(dmem_pkg::ADDR_NV_ADDRESS, 8'h12);
		wr(dmem_pkg::ADDR_NV_DATA, 8'h34);
		wr(dmem_pkg::ADDR_NV_CONTROL, 8'h80);
		`CHK("nv start", 1'b1, nv.start)
		`CHK("nv target", 16'h1234, {nv.addr, nv.data})
		`CHK("code address", 16'h2018, cadr)
	endtask
	// Second reset in mid-run with the port config low
	task automatic t_reset;
		@(posedge sys_clk);
		arst_n <= 1'b0;
		port_reset_high_cfg   <= 1'b0;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		`CHK("latch config low", 8'h00, lat)
		`CHK("pointer re-reset", 8'h07, stk)
	endtask
	task automatic end_sim;
		$display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Watchdog: the whole sequence needs about a hundred cycles
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_mismatch++;
		end_sim();
	end
	initial begin
		arst_n = 1'b0;
		port_reset_high_cfg = 1'b1;
		pins = 8'h00;
		repeat (8) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		t_stack();
		t_bank();
		t_misc();
		t_reset();
		end_sim();
	end
endmodule
`default_nettype wire
